// File: timer_block.sv
`timescale 1ns/1ps
module timer_block #(
  parameter int T2_POST_WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire timer_pkg::reg_req_type req,
  output logic [7:0] rdata,
  input wire logic oscillator_pin,
  input wire logic timer1_external_clock_pin,
  output logic compare_pin,
  output logic special_event_trigger,
  output logic irq
);

  // core phase counter: one instruction cycle is four clk cycles
  timer_pkg::phase_type phase_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_r <= timer_pkg::PH1;
    end else begin
      case (phase_r)
        timer_pkg::PH1: phase_r <= timer_pkg::PH2;
        timer_pkg::PH2: phase_r <= timer_pkg::PH3;
        timer_pkg::PH3: phase_r <= timer_pkg::PH4;
        default: phase_r <= timer_pkg::PH1;
      endcase
    end
  end
  logic second_phase_clock;
  logic fourth_phase_clock;
  assign second_phase_clock = (phase_r == timer_pkg::PH2);
  assign fourth_phase_clock = (phase_r == timer_pkg::PH4);

  // registers
  logic [7:0] interrupt_control_r;
  logic [7:0] peripheral_irq_flags_r;
  logic [7:0] peripheral_irq_enables_r;
  logic [7:0] timer1_control_r;
  logic [7:0] timer2_control_r;
  logic [7:0] timer2_period_value;
  logic [7:0] compare_value_low_r;
  logic [7:0] compare_value_high_r;
  logic [7:0] compare_unit_control_r;
  logic sleep_r;
  logic [15:0] timer1_counter;
  logic [7:0] timer2_counter;

  logic wr_hit_any;
  assign wr_hit_any = req.wr;

  function automatic logic wr_at(input timer_pkg::reg_req_type r, input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction

  // plain configuration registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_control_r <= timer_pkg::RESET_ZERO;
      peripheral_irq_enables_r <= timer_pkg::RESET_ZERO;
      timer1_control_r <= timer_pkg::RESET_ZERO;
      timer2_control_r <= timer_pkg::RESET_ZERO;
      timer2_period_value <= timer_pkg::RESET_TIMER2_PERIOD;
      compare_value_low_r <= timer_pkg::RESET_ZERO;
      compare_value_high_r <= timer_pkg::RESET_ZERO;
      compare_unit_control_r <= timer_pkg::RESET_ZERO;
      sleep_r <= 1'b0;
    end else if (wr_hit_any) begin
      if (wr_at(req, timer_pkg::ADDR_INTERRUPT_CONTROL)) begin
        interrupt_control_r <= req.wdata;
      end else if (wr_at(req, timer_pkg::ADDR_PERIPHERAL_IRQ_ENABLES)) begin
        peripheral_irq_enables_r <= req.wdata & timer_pkg::IRQ_MASK;
      end else if (wr_at(req, timer_pkg::ADDR_TIMER1_CONTROL)) begin
        timer1_control_r <= req.wdata & timer_pkg::T1_CONTROL_MASK;
      end else if (wr_at(req, timer_pkg::ADDR_TIMER2_CONTROL)) begin
        timer2_control_r <= req.wdata & timer_pkg::T2_CONTROL_MASK;
      end else if (wr_at(req, timer_pkg::ADDR_TIMER2_PERIOD)) begin
        timer2_period_value <= req.wdata;
      end else if (wr_at(req, timer_pkg::ADDR_COMPARE_VALUE_LOW)) begin
        compare_value_low_r <= req.wdata;
      end else if (wr_at(req, timer_pkg::ADDR_COMPARE_VALUE_HIGH)) begin
        compare_value_high_r <= req.wdata;
      end else if (wr_at(req, timer_pkg::ADDR_COMPARE_UNIT_CONTROL)) begin
        compare_unit_control_r <= req.wdata & timer_pkg::COMPARE_CONTROL_MASK;
      end else if (wr_at(req, timer_pkg::ADDR_SLEEP_CONTROL)) begin
        sleep_r <= req.wdata[0];
      end
    end
  end

  logic timer1_run;
  logic timer1_source_select;
  logic timer1_sync_disable;
  logic timer1_oscillator_enable;
  logic [1:0] timer1_prescale;
  assign timer1_run = timer1_control_r[timer_pkg::T1_RUN_BIT];
  assign timer1_source_select = timer1_control_r[timer_pkg::T1_SOURCE_BIT];
  assign timer1_sync_disable = timer1_control_r[timer_pkg::T1_SYNC_DIS_BIT];
  assign timer1_oscillator_enable = timer1_control_r[timer_pkg::T1_OSC_EN_BIT];
  assign timer1_prescale = timer1_control_r[timer_pkg::T1_PRESCALE_LSB +: 2];

  logic ext_in;
  assign ext_in = timer1_oscillator_enable ? oscillator_pin : timer1_external_clock_pin;

  // edge detect of the selected pin; inputs are synchronous to clk, so this
  // stands in for the ripple counter clocked by the pin itself
  logic ext_prev_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_in;
    end
  end
  logic ext_rise;
  assign ext_rise = ext_in && !ext_prev_r;

  logic [2:0] t1_pre_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t1_pre_r <= 3'h0;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER1_COUNT_LOW)
                 || wr_at(req, timer_pkg::ADDR_TIMER1_COUNT_HIGH)) begin
      t1_pre_r <= 3'h0; // a count write restarts the prescaler
    end else if (timer1_source_select && ext_rise) begin
      t1_pre_r <= t1_pre_r + 3'h1;
    end
  end

  // symmetric prescaler output: the bit that toggles at the chosen ratio
  logic pre_out;
  always_comb begin
    case (timer1_prescale)
      2'h0: pre_out = ext_in;
      2'h1: pre_out = t1_pre_r[0];
      2'h2: pre_out = t1_pre_r[1];
      default: pre_out = t1_pre_r[2];
    endcase
  end

  // sample on phases two and four
  // sampling is shut off in sleep
  logic samp_a_r;
  logic samp_b_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      samp_a_r <= 1'b0;
      samp_b_r <= 1'b0;
    end else if (!sleep_r && (second_phase_clock || fourth_phase_clock)) begin
      samp_a_r <= pre_out;
      samp_b_r <= samp_a_r;
    end
  end

  // increment lands one sample after the synchronised edge
  logic sync_edge_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_edge_r <= 1'b0;
    end else begin
      sync_edge_r <= !sleep_r && (second_phase_clock || fourth_phase_clock)
                     && samp_a_r && !samp_b_r;
    end
  end

  // async mode: prescaler edge taken directly, no sampling and still live in sleep
  logic pre_prev_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_prev_r <= 1'b0;
    end else begin
      pre_prev_r <= pre_out;
    end
  end
  logic async_edge;
  assign async_edge = pre_out && !pre_prev_r;

  // internal prescaler for timer mode
  logic [2:0] t1_int_pre_r;
  logic t1_int_tick;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t1_int_pre_r <= 3'h0;
    end else if (fourth_phase_clock && !sleep_r) begin
      t1_int_pre_r <= t1_int_pre_r + 3'h1;
    end
  end
  always_comb begin
    case (timer1_prescale)
      2'h0: t1_int_tick = 1'b1;
      2'h1: t1_int_tick = t1_int_pre_r[0];
      2'h2: t1_int_tick = &t1_int_pre_r[1:0];
      default: t1_int_tick = &t1_int_pre_r;
    endcase
  end

  logic t1_inc;
  always_comb begin
    if (!timer1_run) begin
      t1_inc = 1'b0;
    end else if (!timer1_source_select) begin
      t1_inc = fourth_phase_clock && !sleep_r && t1_int_tick;
    end else if (!timer1_sync_disable) begin
      t1_inc = sync_edge_r;
    end else begin
      t1_inc = async_edge;
    end
  end

  // compare unit
  logic [15:0] compare_value;
  assign compare_value = {compare_value_high_r, compare_value_low_r};
  logic [3:0] cmp_mode;
  assign cmp_mode = compare_unit_control_r[3:0];
  logic cmp_active;
  assign cmp_active = (cmp_mode == timer_pkg::CMP_MODE_SET_PIN)
                      || (cmp_mode == timer_pkg::CMP_MODE_CLEAR_PIN)
                      || (cmp_mode == timer_pkg::CMP_MODE_SOFT_IRQ)
                      || (cmp_mode == timer_pkg::CMP_MODE_SPECIAL);
  // match compared on every clk cycle; cmp_event fires only on the first cycle of a match
  logic cmp_match;
  assign cmp_match = cmp_active && (timer1_counter == compare_value) && timer1_run;
  logic cmp_prev_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmp_prev_r <= 1'b0;
    end else begin
      cmp_prev_r <= cmp_match;
    end
  end
  logic cmp_event;
  assign cmp_event = cmp_match && !cmp_prev_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      special_event_trigger <= 1'b0;
    end else begin
      special_event_trigger <= cmp_event && (cmp_mode == timer_pkg::CMP_MODE_SPECIAL);
    end
  end

  // soft-interrupt mode leaves the pin untouched
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      compare_pin <= 1'b0;
    end else if (wr_at(req, timer_pkg::ADDR_COMPARE_UNIT_CONTROL)
                 && (req.wdata[3:0] == timer_pkg::CMP_MODE_SET_PIN
                     || req.wdata[3:0] == timer_pkg::CMP_MODE_CLEAR_PIN)) begin
      // only the pin-driving modes preset the level; other modes keep it
      compare_pin <= (req.wdata[3:0] == timer_pkg::CMP_MODE_CLEAR_PIN);
    end else if (cmp_event && cmp_mode == timer_pkg::CMP_MODE_SET_PIN) begin
      compare_pin <= 1'b1;
    end else if (cmp_event && cmp_mode == timer_pkg::CMP_MODE_CLEAR_PIN) begin
      compare_pin <= 1'b0;
    end
  end

  // timer1 counter; software writes win over hardware
  logic t1_overflow;
  assign t1_overflow = t1_inc && (timer1_counter == 16'hffff);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer1_counter <= 16'h0000;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER1_COUNT_LOW)) begin
      timer1_counter[7:0] <= req.wdata;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER1_COUNT_HIGH)) begin
      timer1_counter[15:8] <= req.wdata;
    end else if (special_event_trigger) begin
      timer1_counter <= 16'h0000;
    end else if (t1_inc) begin
      timer1_counter <= timer1_counter + 16'h0001;
    end
  end

  logic timer2_run;
  assign timer2_run = timer2_control_r[timer_pkg::T2_RUN_BIT];
  logic [1:0] timer2_prescale_select;
  assign timer2_prescale_select = timer2_control_r[timer_pkg::T2_PRESCALE_LSB +: 2];
  logic [T2_POST_WIDTH-1:0] timer2_postscale_select;
  assign timer2_postscale_select = timer2_control_r[timer_pkg::T2_POSTSCALE_LSB +: T2_POST_WIDTH];

  // prescale ratio; counter cleared on any write to count or control
  logic [3:0] t2_pre_r;
  logic t2_tick;
  always_comb begin
    if (!timer2_prescale_select[1]) begin
      t2_tick = timer2_prescale_select[0] ? (t2_pre_r[1:0] == 2'h3) : 1'b1;
    end else begin
      t2_tick = (t2_pre_r == 4'hf);
    end
  end
  logic t2_cycle;
  assign t2_cycle = timer2_run && fourth_phase_clock && !sleep_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t2_pre_r <= 4'h0;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER2_COUNT)
                 || wr_at(req, timer_pkg::ADDR_TIMER2_CONTROL)) begin
      t2_pre_r <= 4'h0;
    end else if (t2_cycle) begin
      t2_pre_r <= t2_pre_r + 4'h1;
    end
  end

  logic t2_match;
  assign t2_match = t2_cycle && t2_tick && (timer2_counter == timer2_period_value);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer2_counter <= 8'h00;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER2_COUNT)) begin
      timer2_counter <= req.wdata;
    end else if (t2_match) begin
      timer2_counter <= 8'h00;
    end else if (t2_cycle && t2_tick) begin
      timer2_counter <= timer2_counter + 8'h01;
    end
  end

  // postscaler divides matches by field plus one
  logic [T2_POST_WIDTH-1:0] t2_post_r;
  logic t2_flag_event;
  assign t2_flag_event = t2_match && (t2_post_r == timer2_postscale_select);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      t2_post_r <= '0;
    end else if (wr_at(req, timer_pkg::ADDR_TIMER2_COUNT)
                 || wr_at(req, timer_pkg::ADDR_TIMER2_CONTROL)) begin
      t2_post_r <= '0;
    end else if (t2_flag_event) begin
      t2_post_r <= '0;
    end else if (t2_match) begin
      t2_post_r <= t2_post_r + T2_POST_WIDTH'(1);
    end
  end

  // sticky flags; a set in the same cycle as a clear wins
  logic [7:0] flag_set;
  always_comb begin
    flag_set = 8'h00;
    flag_set[timer_pkg::IRQ_T1_OVF_BIT] = t1_overflow;
    flag_set[timer_pkg::IRQ_T2_MATCH_BIT] = t2_flag_event;
    // compare flag set in every compare mode
    flag_set[timer_pkg::IRQ_COMPARE_BIT] = cmp_event;
  end
  logic [7:0] flag_clr;
  assign flag_clr = wr_at(req, timer_pkg::ADDR_IRQ_CLEAR) ? req.wdata : 8'h00;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peripheral_irq_flags_r <= timer_pkg::RESET_ZERO;
    end else begin
      peripheral_irq_flags_r <= ((peripheral_irq_flags_r & ~flag_clr) | flag_set)
                                & timer_pkg::IRQ_MASK;
    end
  end

  // interrupt: enabled flag gated by global and peripheral enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(peripheral_irq_flags_r & peripheral_irq_enables_r)
             && interrupt_control_r[timer_pkg::GLOBAL_IRQ_BIT]
             && interrupt_control_r[timer_pkg::PERIPH_IRQ_BIT];
    end
  end

  // read data the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (!req.rd) begin
      rdata <= 8'h00;
    end else if (req.addr == timer_pkg::ADDR_INTERRUPT_CONTROL) begin
      rdata <= interrupt_control_r;
    end else if (req.addr == timer_pkg::ADDR_PERIPHERAL_IRQ_FLAGS) begin
      rdata <= peripheral_irq_flags_r;
    end else if (req.addr == timer_pkg::ADDR_TIMER1_COUNT_LOW) begin
      rdata <= timer1_counter[7:0];
    end else if (req.addr == timer_pkg::ADDR_TIMER1_COUNT_HIGH) begin
      rdata <= timer1_counter[15:8];
    end else if (req.addr == timer_pkg::ADDR_TIMER1_CONTROL) begin
      rdata <= timer1_control_r;
    end else if (req.addr == timer_pkg::ADDR_TIMER2_COUNT) begin
      rdata <= timer2_counter;
    end else if (req.addr == timer_pkg::ADDR_TIMER2_CONTROL) begin
      rdata <= timer2_control_r;
    end else if (req.addr == timer_pkg::ADDR_COMPARE_VALUE_LOW) begin
      rdata <= compare_value_low_r;
    end else if (req.addr == timer_pkg::ADDR_COMPARE_VALUE_HIGH) begin
      rdata <= compare_value_high_r;
    end else if (req.addr == timer_pkg::ADDR_COMPARE_UNIT_CONTROL) begin
      rdata <= compare_unit_control_r;
    end else if (req.addr == timer_pkg::ADDR_PERIPHERAL_IRQ_ENABLES) begin
      rdata <= peripheral_irq_enables_r;
    end else if (req.addr == timer_pkg::ADDR_TIMER2_PERIOD) begin
      rdata <= timer2_period_value;
    end else if (req.addr == timer_pkg::ADDR_SLEEP_CONTROL) begin
      rdata <= {7'h00, sleep_r};
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// File: timer_pkg.sv
package timer_pkg;
  // register offsets (8-bit address space)
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h0e;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h0f;
  localparam logic [7:0] ADDR_TIMER1_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_TIMER2_COUNT = 8'h11;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_COMPARE_VALUE_LOW = 8'h15;
  localparam logic [7:0] ADDR_COMPARE_VALUE_HIGH = 8'h16;
  localparam logic [7:0] ADDR_COMPARE_UNIT_CONTROL = 8'h17;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h9c;
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h9d;

  // reset values
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_TIMER2_PERIOD = 8'hff;

  // timer1 control fields
  localparam int T1_RUN_BIT = 0;
  localparam int T1_SOURCE_BIT = 1;
  localparam int T1_SYNC_DIS_BIT = 2;
  localparam int T1_OSC_EN_BIT = 3;
  localparam int T1_PRESCALE_LSB = 4;
  localparam logic [7:0] T1_CONTROL_MASK = 8'h3f;

  // timer2 control fields
  localparam int T2_PRESCALE_LSB = 0;
  localparam int T2_RUN_BIT = 2;
  localparam int T2_POSTSCALE_LSB = 3;
  localparam logic [7:0] T2_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] COMPARE_CONTROL_MASK = 8'h3f;

  // irq flag positions
  localparam int IRQ_T1_OVF_BIT = 0;
  localparam int IRQ_T2_MATCH_BIT = 1;
  localparam int IRQ_COMPARE_BIT = 2;
  localparam logic [7:0] IRQ_MASK = 8'h07;

  // compare modes held in the low nibble of compare control
  localparam logic [3:0] CMP_MODE_SET_PIN = 4'h8;
  localparam logic [3:0] CMP_MODE_CLEAR_PIN = 4'h9;
  localparam logic [3:0] CMP_MODE_SOFT_IRQ = 4'ha;
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;

  // interrupt control global enables
  localparam int GLOBAL_IRQ_BIT = 7;
  localparam int PERIPH_IRQ_BIT = 6;

  // instruction clock is oscillator divided by four phases
  localparam int PHASES_PER_CYCLE = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef enum logic [1:0] {PH1, PH2, PH3, PH4} phase_type;
endpackage

// File: timer_block_props.sv
`timescale 1ns/1ps
// port checker; mirrors the few written registers whose effect shows at the ports
module timer_block_props #(
  parameter int T2_POST_WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire timer_pkg::reg_req_type req,
  input wire logic [7:0] rdata,
  input wire logic oscillator_pin,
  input wire logic timer1_external_clock_pin,
  input wire logic compare_pin,
  input wire logic special_event_trigger,
  input wire logic irq
);
  logic [3:0] mode_r;
  logic [7:0] t1c_r;
  logic [7:0] t2c_r;
  logic [7:0] en_r;
  logic gate_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // mirror of the masked control bytes, taken at the write edge like the design
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= 4'h0;
      t1c_r <= 8'h00;
      t2c_r <= 8'h00;
      en_r <= 8'h00;
      gate_r <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == timer_pkg::ADDR_COMPARE_UNIT_CONTROL) mode_r <= req.wdata[3:0];
      if (req.addr == timer_pkg::ADDR_TIMER1_CONTROL) t1c_r <= req.wdata & 8'h3f;
      if (req.addr == timer_pkg::ADDR_TIMER2_CONTROL) t2c_r <= req.wdata & 8'h7f;
      if (req.addr == timer_pkg::ADDR_PERIPHERAL_IRQ_ENABLES) en_r <= req.wdata & 8'h07;
      if (req.addr == timer_pkg::ADDR_INTERRUPT_CONTROL) gate_r <= req.wdata[7] & req.wdata[6];
    end
  end
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property ($past(req.rd) && $past(req.addr) == 8'h00 |-> rdata == 8'h00)
    else $error("unmapped read returned data");
  t2_readback_a: assert property ($past(req.rd) && $past(req.addr) == 8'h12 |-> rdata == $past(t2c_r))
    else $error("timer2 control read back wrong");
  t1_readback_a: assert property ($past(req.rd) && $past(req.addr) == 8'h10 |-> rdata == $past(t1c_r))
    else $error("timer1 control read back wrong");
  trigger_pulse_a: assert property (special_event_trigger |=> !special_event_trigger)
    else $error("trigger longer than one cycle");
  trigger_mode_a: assert property (special_event_trigger |-> $past(mode_r) == 4'hb)
    else $error("trigger outside special event mode");
  soft_pin_a: assert property (mode_r == 4'ha && $past(mode_r) == 4'ha |-> $stable(compare_pin))
    else $error("compare pin moved in soft interrupt mode");
  irq_gate_a: assert property (irq |-> $past(gate_r))
    else $error("interrupt with global gate closed");
  irq_enable_a: assert property (irq |-> $past(en_r) != 8'h00)
    else $error("interrupt with no source enabled");
endmodule
bind timer_block timer_block_props #(.T2_POST_WIDTH(T2_POST_WIDTH)) u_props (.clk(clk),
  .reset(reset), .req(req), .rdata(rdata), .oscillator_pin(oscillator_pin),
  .timer1_external_clock_pin(timer1_external_clock_pin), .compare_pin(compare_pin),
  .special_event_trigger(special_event_trigger), .irq(irq));

// File: ext_clock_source.sv
`timescale 1ns/1ps
// external clock source; stands low whenever it is not running
module ext_clock_source (
  input wire logic clk,
  input wire logic run,
  input wire logic use_osc,
  input wire logic [3:0] half,
  output logic oscillator_pin,
  output logic timer1_external_clock_pin,
  output int edges
);
  logic level_r;
  logic [3:0] cnt_r;
  initial begin
    level_r = 1'b0;
    cnt_r = 4'h0;
    edges = 0;
  end
  assign oscillator_pin = use_osc & level_r;
  assign timer1_external_clock_pin = ~use_osc & level_r;
  // levels held three clocks or more so at least one phase sample sees them
  always @(posedge clk) begin
    if (!run) begin
      level_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (cnt_r + 4'h1 >= half) begin
      cnt_r <= 4'h0;
      level_r <= ~level_r;
      if (!level_r) edges <= edges + 1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// File: timer_block_bench.sv
`timescale 1ns/1ps
module timer_block_bench;
  localparam logic [7:0] A_T1L = timer_pkg::ADDR_TIMER1_COUNT_LOW;
  localparam logic [7:0] A_T1H = timer_pkg::ADDR_TIMER1_COUNT_HIGH;
  localparam logic [7:0] A_T1C = timer_pkg::ADDR_TIMER1_CONTROL;
  localparam logic [7:0] A_T2C = timer_pkg::ADDR_TIMER2_CONTROL;
  localparam logic [7:0] A_CLR = timer_pkg::ADDR_IRQ_CLEAR;
  localparam logic [7:0] A_EN = timer_pkg::ADDR_PERIPHERAL_IRQ_ENABLES;
  localparam logic [7:0] A_CMC = timer_pkg::ADDR_COMPARE_UNIT_CONTROL;
  logic clk;
  logic reset;
  timer_pkg::reg_req_type req;
  logic [7:0] rdata;
  logic osc_pin;
  logic ext_pin;
  logic compare_pin;
  logic trig;
  logic irq;
  logic src_run;
  logic src_osc;
  logic [3:0] src_half;
  logic [7:0] rv;
  logic [7:0] rv2;
  logic [7:0] pr;
  logic [3:0] po;
  logic [15:0] t1v;
  logic [7:0] cfg [3] = '{8'h03, 8'h0b, 8'h13};
  logic [7:0] ra [8] = '{8'h0c, 8'h10, 8'h11, 8'h12, 8'h17, 8'h8c, 8'h92, 8'h00};
  int edges;
  int trig_seen;
  int failures;
  int n_checks;
  int n;
  int e0;
  int ex;
  timer_block dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata), .oscillator_pin(osc_pin),
    .timer1_external_clock_pin(ext_pin), .compare_pin(compare_pin),
    .special_event_trigger(trig), .irq(irq));
  ext_clock_source src (.clk(clk), .run(src_run), .use_osc(src_osc), .half(src_half),
    .oscillator_pin(osc_pin), .timer1_external_clock_pin(ext_pin), .edges(edges));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // count trigger pulses
  always @(posedge clk) begin
    if (trig === 1'b1) trig_seen <= trig_seen + 1;
  end
  // cuts a hang short
  initial begin
    #(8 * 60000);
    failures++;
    stop_test();
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // timer1 is read only while stopped, so the two bytes agree
  task automatic rd16(output logic [15:0] v);
    rd(A_T1L, v[7:0]);
    rd(A_T1H, v[15:8]);
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    while (irq !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
  endtask
  function automatic int t2_ticks(input int c, input int p, input int q);
    return (p + 1) * (c == 0 ? 1 : (c == 1 ? 4 : 16)) * (q + 1) * 4;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    req = '0;
    src_run = 1'b0;
    src_osc = 1'b0;
    src_half = 4'h3;
    trig_seen = 0;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'h4990));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    // reset values, period all ones, unmapped zero
    foreach (ra[i]) begin
      rd(ra[i], rv);
      chk(rv, ra[i] == 8'h92 ? 8'hff : 8'h00);
    end
    wr(A_T2C, 8'hff);
    rd(A_T2C, rv);
    chk(rv, 8'h7f);
    $display("test reset done");
    // flag spacing over every prescale code
    wr(A_EN, 8'h02);
    wr(timer_pkg::ADDR_INTERRUPT_CONTROL, 8'hc0);
    for (int c = 0; c < 4; c++) begin
      pr = 8'($urandom_range(7, 1));
      po = (c == 0) ? 4'hf : 4'($urandom_range(3, 0));
      wr(A_T2C, 8'h00);
      wr(A_CLR, 8'h07);
      wr(timer_pkg::ADDR_TIMER2_PERIOD, pr);
      wr(timer_pkg::ADDR_TIMER2_COUNT, 8'h00);
      wr(A_T2C, {1'b0, po, 1'b1, 2'(c)});
      wait_irq(n);
      ex = t2_ticks(c, pr, po);
      chk(16'(n >= ex - 4 && n <= ex + 8), 16'h1);
    end
    wr(A_T2C, 8'h00);
    rd(timer_pkg::ADDR_TIMER2_COUNT, rv);
    repeat (100) @(posedge clk);
    rd(timer_pkg::ADDR_TIMER2_COUNT, rv2);
    chk(rv2, rv);
    wr(A_CLR, 8'h07);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("test timer2 done");
    // one count per instruction cycle, sync bit ignored
    for (int s = 0; s < 2; s++) begin
      wr(A_T1L, 8'h00);
      wr(A_T1H, 8'h00);
      wr(A_T1C, 8'(s << 2) | 8'h01);
      repeat (398) @(posedge clk);
      wr(A_T1C, 8'h00);
      rd16(t1v);
      chk(16'(t1v >= 16'd99 && t1v <= 16'd101), 16'h1);
    end
    for (int k = 0; k < 4; k++) begin
      src_osc <= (k == 1);
      src_half <= 4'($urandom_range(8, 3));
      wr(A_T1L, 8'h00);
      wr(A_T1H, 8'h00);
      wr(A_T1C, cfg[k % 3]);
      if (k == 3) wr(timer_pkg::ADDR_SLEEP_CONTROL, 8'h01);
      e0 = edges;
      src_run <= 1'b1;
      repeat (300) @(posedge clk);
      src_run <= 1'b0;
      repeat (20) @(posedge clk);
      wr(A_T1C, 8'h00);
      wr(timer_pkg::ADDR_SLEEP_CONTROL, 8'h00);
      rd16(t1v);
      ex = (k == 3) ? 0 : ((k == 2) ? (edges - e0) / 2 : edges - e0);
      chk(16'(t1v >= 16'(ex) && t1v <= 16'(ex + (k == 2))), 16'h1);
    end
    $display("test timer1 done");
    // soft interrupt: flag masked, then raised, pin left high
    wr(A_EN, 8'h00);
    wr(timer_pkg::ADDR_COMPARE_VALUE_LOW, 8'd20);
    wr(timer_pkg::ADDR_COMPARE_VALUE_HIGH, 8'h00);
    wr(A_CMC, {4'h0, timer_pkg::CMP_MODE_CLEAR_PIN});
    wr(A_CMC, {4'h0, timer_pkg::CMP_MODE_SOFT_IRQ});
    wr(A_CLR, 8'h07);
    wr(A_T1C, 8'h01);
    repeat (200) @(posedge clk);
    chk(irq, 1'b0);
    rd(timer_pkg::ADDR_PERIPHERAL_IRQ_FLAGS, rv);
    chk(rv, 8'h04);
    wr(A_EN, 8'h04);
    repeat (3) @(posedge clk);
    chk({irq, compare_pin}, 2'b11);
    wr(A_CLR, 8'h04);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("test soft compare done");
    // special event clears timer1 so compare acts as the period
    wr(A_T1C, 8'h00);
    wr(A_T1L, 8'h00);
    wr(timer_pkg::ADDR_COMPARE_VALUE_LOW, 8'd30);
    wr(A_CMC, {4'h0, timer_pkg::CMP_MODE_SPECIAL});
    e0 = trig_seen;
    wr(A_T1C, 8'h01);
    repeat (432) @(posedge clk);
    wr(A_T1C, 8'h00);
    chk(16'(trig_seen - e0), 16'd3);
    rd16(t1v);
    chk(16'(t1v <= 16'd30), 16'h1);
    // pin-driving mode contrast: preset low, match drives high
    wr(A_CMC, {4'h0, timer_pkg::CMP_MODE_SET_PIN});
    @(posedge clk);
    chk(compare_pin, 1'b0);
    wr(A_T1C, 8'h01);
    repeat (130) @(posedge clk);
    chk(compare_pin, 1'b1);
    wr(A_T1C, 8'h00);
    $display("test special event done");
    stop_test();
  end
endmodule
